// ---- common/uhpf_pkg.sv ----
// Package of constants for the USB host pipe event flag block
package uhpf_pkg;
    // Register index as printed; byte address is four times it
    localparam int unsigned FLAGS_IDX      = 32'h0000_0107;
    localparam logic [11:0] ADDR_FLAGS     = 12'(FLAGS_IDX * 4);
    localparam logic [11:0] ADDR_ENABLE    = 12'h800;
    localparam logic [11:0] ADDR_CTRL      = 12'h804;
    localparam logic [11:0] ADDR_IRQ_STAT  = 12'h808;
    localparam logic [11:0] ADDR_IRQ_MASK  = 12'h80C;
    localparam logic [11:0] ADDR_PIPE_SEL  = 12'h810;

    localparam int unsigned BIT_DONE       = 0;
    localparam int unsigned BIT_FAIL       = 2;
    localparam int unsigned BIT_PIPE_ERROR_FLAG       = 3;
    localparam int unsigned BIT_SETUP      = 4;
    localparam int unsigned BIT_STALL      = 5;
    localparam logic [7:0]  FLAG_MASK      = 8'h3D;
    localparam logic [7:0]  FLAG_RESET     = 8'h00;
    localparam logic [7:0]  ENABLE_RESET   = 8'h00;

    localparam int unsigned CTRL_SOF_BIT   = 0;
    localparam logic [1:0]  BRESP_OKAY     = 2'h0;
    localparam logic [1:0]  BRESP_SLVERR   = 2'h2;
endpackage

// ---- hw/uhpf_flags.sv ----
// USB host pipe event flags with AXI4-Lite register slave
// Overview of operation
// [R1] A stall handshake on a pipe sets its stall flag, which interrupts when its enable is one.
// [R2] A completed setup on a pipe sets its setup-sent flag, which interrupts when its enable is one.
// [R3] A detected pipe error sets the pipe-error flag, which interrupts while its enable is one.
// [R4] A failed transfer sets the transfer-fail flag, which interrupts when its enable is one.
// [R5] Transfer complete sets the done flag on a single-bank pipe, or on a double-bank pipe only in bank 0.
// [R6] Writing one to a flag bit clears it and writing zero leaves it alone.
// [R7] Resuming from L1 sleep sets the frame-start enable so frame-start generation restarts.
// [R8] Each pipe raises a request while any set flag has its enable set.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module uhpf_flags
    import uhpf_pkg::*;
#(
    parameter int unsigned PIPES = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [PIPES-1:0] stall_rx,
    input  wire logic [PIPES-1:0] setup_sent,
    input  wire logic [PIPES-1:0] pipe_error,
    input  wire logic [PIPES-1:0] transfer_fail,
    input  wire logic [PIPES-1:0] transfer_done,
    input  wire logic [PIPES-1:0] pipe_double_bank,
    input  wire logic [PIPES-1:0] pipe_current_bank,
    input  wire logic             l1_resume,
    input  wire logic [11:0]      s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [11:0]      s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    output logic [PIPES-1:0]      pipe_irq,
    output logic                  frame_start_enable,
    output logic                  irq
);
    localparam int unsigned SW = (PIPES > 1) ? $clog2(PIPES) : 1;

    logic [7:0]       host_pipe_event_flags_r [PIPES];
    logic [7:0]       pipe_event_enable_r [PIPES];
    logic [SW-1:0]    pipe_sel_r;
    logic [PIPES-1:0] irq_stat_r;
    logic [PIPES-1:0] irq_mask_r;
    logic [11:0]      aw_addr_r;
    logic             aw_held_r;
    logic [31:0]      w_data_r;
    logic [3:0]       w_strb_r;
    logic             w_held_r;
    logic             wr_go;
    logic [PIPES-1:0] pipe_req;
    logic [7:0]       flag_set [PIPES];
    logic [7:0]       flag_clr [PIPES];
    logic [PIPES-1:0] stat_clr;
    logic [31:0]      rd_word;
    logic             wr_flags;
    logic             wr_enable;
    logic             wr_ctrl;
    logic             wr_stat;
    logic             wr_mask;
    logic             wr_sel;

    // Byte-enable merge of write data into an 8-bit low field
    function automatic logic [7:0] lo_merge(input logic [7:0] old, input logic [31:0] d, input logic [3:0] s);
        lo_merge = s[0] ? d[7:0] : old;
    endfunction

    function automatic logic known_addr(input logic [11:0] a);
        known_addr = (a == ADDR_FLAGS) || (a == ADDR_ENABLE) || (a == ADDR_CTRL) ||
                     (a == ADDR_IRQ_STAT) || (a == ADDR_IRQ_MASK) || (a == ADDR_PIPE_SEL);
    endfunction

    function automatic logic wr_hit(input logic go, input logic [11:0] held, input logic [11:0] a);
        wr_hit = go && (held == a);
    endfunction

    // Write address and data accepted in either order
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 12'h000;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end
    end

    // Write lands once both halves are held and no response waits
    assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

    // Register write strobes, byte lane 0 for the 8-bit fields
    assign wr_flags  = wr_hit(wr_go, aw_addr_r, ADDR_FLAGS) && w_strb_r[0];
    assign wr_enable = wr_hit(wr_go, aw_addr_r, ADDR_ENABLE);
    assign wr_ctrl   = wr_hit(wr_go, aw_addr_r, ADDR_CTRL) && w_strb_r[0];
    assign wr_stat   = wr_hit(wr_go, aw_addr_r, ADDR_IRQ_STAT);
    assign wr_mask   = wr_hit(wr_go, aw_addr_r, ADDR_IRQ_MASK);
    assign wr_sel    = wr_hit(wr_go, aw_addr_r, ADDR_PIPE_SEL) && w_strb_r[0];

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
        end else if (wr_go) begin
            s_axi_bvalid <= 1'b1;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_bresp <= BRESP_OKAY;
        end else if (wr_go) begin
            s_axi_bresp <= known_addr(aw_addr_r) ? BRESP_OKAY : BRESP_SLVERR;
        end
    end

    // Per-pipe set and clear vectors
    always_comb begin
        for (int p = 0; p < PIPES; p++) begin
            flag_set[p]            = 8'h00;
            flag_set[p][BIT_STALL] = stall_rx[p]; // R1
            flag_set[p][BIT_SETUP] = setup_sent[p]; // R2
            flag_set[p][BIT_PIPE_ERROR_FLAG]  = pipe_error[p]; // R3
            flag_set[p][BIT_FAIL]  = transfer_fail[p]; // R4
            flag_set[p][BIT_DONE]  = transfer_done[p] && (!pipe_double_bank[p] || !pipe_current_bank[p]); // R5
            flag_clr[p]            = 8'h00;
            if (wr_flags && pipe_sel_r == SW'(p)) begin
                flag_clr[p] = w_data_r[7:0] & FLAG_MASK; // R6
            end
        end
    end

    // Per-pipe flags: hardware set wins over software clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < PIPES; p++) begin
                host_pipe_event_flags_r[p] <= FLAG_RESET;
            end
        end else begin
            for (int p = 0; p < PIPES; p++) begin
                host_pipe_event_flags_r[p] <= (host_pipe_event_flags_r[p] & ~flag_clr[p]) | flag_set[p];
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int p = 0; p < PIPES; p++) begin
                pipe_event_enable_r[p] <= ENABLE_RESET;
            end
        end else if (wr_enable) begin
            pipe_event_enable_r[pipe_sel_r] <= lo_merge(pipe_event_enable_r[pipe_sel_r], w_data_r, w_strb_r)
                                               & FLAG_MASK;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pipe_sel_r <= '0;
        end else if (wr_sel) begin
            pipe_sel_r <= w_data_r[SW-1:0];
        end
    end

    // Frame-start enable, forced on by L1 resume
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            frame_start_enable <= 1'b0;
        end else if (l1_resume) begin
            frame_start_enable <= 1'b1; // R7
        end else if (wr_ctrl) begin
            frame_start_enable <= w_data_r[CTRL_SOF_BIT];
        end
    end

    always_comb begin
        for (int p = 0; p < PIPES; p++) begin
            pipe_req[p] = |(host_pipe_event_flags_r[p] & pipe_event_enable_r[p]); // R8
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pipe_irq <= '0;
        end else begin
            pipe_irq <= pipe_req; // R1 R2 R3 R4 R5 R8
        end
    end

    // Sticky summary status per pipe, set wins over write-one clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_stat_r <= '0;
        end else begin
            irq_stat_r <= (irq_stat_r & ~stat_clr) | pipe_req;
        end
    end

    always_comb begin
        stat_clr = '0;
        if (wr_stat) begin
            stat_clr = w_data_r[PIPES-1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_mask_r <= '0;
        end else if (wr_mask) begin
            irq_mask_r <= w_data_r[PIPES-1:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_r & irq_mask_r);
        end
    end

    // Read channel: one-cycle accept, data next cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
        end
    end

    // Read word of the addressed register
    always_comb begin
        unique case (s_axi_araddr)
            ADDR_FLAGS:    rd_word = {24'h000000, host_pipe_event_flags_r[pipe_sel_r]};
            ADDR_ENABLE:   rd_word = {24'h000000, pipe_event_enable_r[pipe_sel_r]};
            ADDR_CTRL:     rd_word = {31'h0000_0000, frame_start_enable};
            ADDR_IRQ_STAT: rd_word = 32'(irq_stat_r);
            ADDR_IRQ_MASK: rd_word = 32'(irq_mask_r);
            ADDR_PIPE_SEL: rd_word = 32'(pipe_sel_r);
            default:       rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= BRESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= known_addr(s_axi_araddr) ? BRESP_OKAY : BRESP_SLVERR;
        end
    end
endmodule

// ---- tb/uhpf_sva.sv ----
// Checker for the pipe event flag block ports
`timescale 1ns/1ps
module uhpf_sva
    import uhpf_pkg::*;
#(
    parameter int unsigned PIPES = 8
) (
    input wire logic             ref_clk,
    input wire logic             rst,
    input wire logic             s_axi_awready,
    input wire logic             s_axi_bvalid,
    input wire logic             s_axi_arvalid,
    input wire logic             s_axi_arready,
    input wire logic             s_axi_rvalid,
    input wire logic             l1_resume,
    input wire logic             frame_start_enable,
    input wire logic [PIPES-1:0] pipe_irq,
    input wire logic             irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Bench keeps bready and rready high
    aw_hold_a: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw early");
    b_once_a: assert property (s_axi_bvalid |=> !s_axi_bvalid) else $error("b stuck");
    ar_hold_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar early");
    r_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("r late");
    r_once_a: assert property (s_axi_rvalid |=> !s_axi_rvalid) else $error("r stuck");
    sof_set_a: assert property (l1_resume |=> frame_start_enable) else $error("sof off");
    pirq_keep_a: assert property ($fell(pipe_irq[1]) && !$past(s_axi_bvalid) |-> ##[0:2] s_axi_bvalid)
        else $error("pipe irq drop");
    irq_src_a: assert property ($rose(irq) |-> $past(|pipe_irq)) else $error("irq stray");
    cover property (l1_resume);
    cover property ($rose(irq));
    cover property ($fell(pipe_irq[1]));
endmodule

// ---- tb/uhpf_usb_dev.sv ----
// Model of devices on the host port raising pipe events
`timescale 1ns/1ps
module uhpf_usb_dev
    import uhpf_pkg::*;
#(
    parameter int unsigned PIPES = 8
) (
    input wire logic         ref_clk,
    output logic [PIPES-1:0] stl,
    output logic [PIPES-1:0] stp,
    output logic [PIPES-1:0] per,
    output logic [PIPES-1:0] tfl,
    output logic [PIPES-1:0] tdn
);
    initial {stl, stp, per, tfl, tdn} = '0;
    task automatic pulse(input int k, input int p);
        case (k)
            5: stl[p] <= 1'b1;
            4: stp[p] <= 1'b1;
            3: per[p] <= 1'b1;
            2: tfl[p] <= 1'b1;
            default: tdn[p] <= 1'b1;
        endcase
        @(posedge ref_clk);
        {stl, stp, per, tfl, tdn} <= '0;
    endtask
endmodule

// ---- tb/uhpf_flags_tb_top.sv ----
// Testbench for the USB host pipe event flag block
`timescale 1ns/1ps
module uhpf_flags_tb_top
    import uhpf_pkg::*;
;
    localparam int unsigned PIPES = 4;
    logic             ref_clk, rst, l1, fse, irq, awv, awr, wv, wrd, bv, arv, arr, rv, rdy;
    logic [1:0]       bresp, rresp;
    logic [11:0]      awa, ara;
    logic [31:0]      wd, rdat;
    logic [3:0]       ws;
    logic [PIPES-1:0] stl, stp, per, tfl, tdn, dbl, cur, pirq;
    int               n_fail, checks_done, cyc;

    uhpf_usb_dev #(.PIPES(PIPES)) u_uhpf_usb_dev (.ref_clk(ref_clk), .stl(stl), .stp(stp), .per(per), .tfl(tfl),
        .tdn(tdn));
    uhpf_flags #(.PIPES(PIPES)) u_uhpf_flags (.ref_clk(ref_clk), .rst(rst), .stall_rx(stl), .setup_sent(stp),
        .pipe_error(per), .transfer_fail(tfl), .transfer_done(tdn), .pipe_double_bank(dbl), .pipe_current_bank(cur),
        .l1_resume(l1), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(rdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rdy), .pipe_irq(pirq), .frame_start_enable(fse),
        .irq(irq));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = BRESP_OKAY);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv);
        chk("bresp", 32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er = BRESP_OKAY);
        ara <= a;
        arv <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        chk("rdata", rdat, e);
        chk("rresp", 32'(rresp), 32'(er));
    endtask

    task automatic t_flags();
        int b[5] = '{5, 4, 3, 2, 0};
        rd(ADDR_FLAGS, 32'(FLAG_RESET));
        wr(ADDR_PIPE_SEL, 32'h1);
        foreach (b[i]) begin
            wr(ADDR_ENABLE, 32'h1 << b[i]);
            u_uhpf_usb_dev.pulse(b[i], 1);
            repeat (2) @(posedge ref_clk);
            chk("pipe_irq", 32'(pirq), 32'h2);
            rd(ADDR_FLAGS, 32'h1 << b[i]);
            wr(ADDR_FLAGS, ~(32'h1 << b[i]));
            rd(ADDR_FLAGS, 32'h1 << b[i]);
            wr(ADDR_FLAGS, 32'h1 << b[i]);
            rd(ADDR_FLAGS, 32'h0);
            chk("pipe_irq", 32'(pirq), 32'h0);
        end
        $display("t_flags end");
    endtask
    task automatic t_bank();
        logic [1:0] cfg[3] = '{2'b11, 2'b10, 2'b01};
        foreach (cfg[i]) begin
            dbl[1] <= cfg[i][1];
            cur[1] <= cfg[i][0];
            @(posedge ref_clk);
            u_uhpf_usb_dev.pulse(0, 1);
            rd(ADDR_FLAGS, 32'(cfg[i] != 2'b11));
            wr(ADDR_FLAGS, 32'h1);
        end
        $display("t_bank end");
    endtask
    task automatic t_irq();
        wr(ADDR_IRQ_MASK, 32'h0);
        wr(ADDR_IRQ_STAT, 32'hF);
        wr(ADDR_ENABLE, 32'h20);
        u_uhpf_usb_dev.pulse(5, 1);
        repeat (3) @(posedge ref_clk);
        chk("irq", 32'(irq), 32'h0);
        rd(ADDR_IRQ_STAT, 32'h2);
        ws <= 4'hE;
        wr(ADDR_FLAGS, 32'h20);
        ws <= 4'hF;
        rd(ADDR_FLAGS, 32'h20);
        wr(ADDR_IRQ_MASK, 32'hF);
        repeat (3) @(posedge ref_clk);
        chk("irq", 32'(irq), 32'h1);
        wr(ADDR_FLAGS, 32'h20);
        wr(ADDR_IRQ_STAT, 32'h2);
        repeat (3) @(posedge ref_clk);
        chk("irq", 32'(irq), 32'h0);
        $display("t_irq end");
    endtask
    task automatic t_misc();
        rd(ADDR_CTRL, 32'h0);
        l1 <= 1'b1;
        @(posedge ref_clk);
        l1 <= 1'b0;
        @(posedge ref_clk);
        rd(ADDR_CTRL, 32'h1);
        wr(ADDR_CTRL, 32'h0);
        @(posedge ref_clk);
        chk("fse", 32'(fse), 32'h0);
        wr(12'h900, 32'h1, BRESP_SLVERR);
        rd(12'h900, 32'h0, BRESP_SLVERR);
        $display("t_misc end");
    endtask

    initial begin
        {rst, rdy} = 2'h3;
        {l1, awv, wv, arv, dbl, cur, awa, ara, wd} = '0;
        ws = 4'hF;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        t_flags();
        t_bank();
        t_irq();
        t_misc();
        close_out();
    end
endmodule

bind uhpf_flags uhpf_sva #(.PIPES(PIPES)) u_uhpf_sva (.ref_clk(ref_clk), .rst(rst), .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .l1_resume(l1_resume), .frame_start_enable(frame_start_enable),
    .pipe_irq(pipe_irq), .irq(irq));
